// File: verilog/swr_pkg.sv
package swr_pkg;

  // ---------------------------------------------------------------
  // rom function command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_READ_ROM = 8'h33;
  localparam logic [7:0] CMD_MATCH_ROM = 8'h55;
  localparam logic [7:0] CMD_SEARCH_ROM = 8'hF0;
  localparam logic [7:0] CMD_SKIP_ROM = 8'hCC;
  localparam logic [7:0] CMD_RESUME = 8'hA5;
  localparam logic [7:0] CMD_OD_SKIP = 8'h3C;
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;

  localparam int ID_BITS = 64;
  localparam int CMD_BITS = 8;

  // ---------------------------------------------------------------
  // timing in ns and derived cycle counts at 125 MHz
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int RST_STD_NS = 120000;
  localparam int RST_OD_NS = 16000;
  localparam int RST_LONG_NS = 480000;
  localparam int SAMPLE_STD_NS = 30000;
  localparam int SAMPLE_OD_NS = 3000;
  localparam int HOLD0_STD_NS = 45000;
  localparam int HOLD0_OD_NS = 5000;
  localparam int PRES_WAIT_STD_NS = 30000;
  localparam int PRES_WAIT_OD_NS = 3000;
  localparam int PRES_LOW_STD_NS = 120000;
  localparam int PRES_LOW_OD_NS = 12000;

  localparam int RST_STD_CYC = (RST_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_OD_CYC = (RST_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_LONG_CYC = (RST_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_STD_CYC = SAMPLE_STD_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_OD_CYC = SAMPLE_OD_NS / CLK_PERIOD_NS;
  localparam int HOLD0_STD_CYC = HOLD0_STD_NS / CLK_PERIOD_NS;
  localparam int HOLD0_OD_CYC = HOLD0_OD_NS / CLK_PERIOD_NS;
  localparam int PRES_WAIT_STD_CYC = PRES_WAIT_STD_NS / CLK_PERIOD_NS;
  localparam int PRES_WAIT_OD_CYC = PRES_WAIT_OD_NS / CLK_PERIOD_NS;
  localparam int PRES_LOW_STD_CYC = PRES_LOW_STD_NS / CLK_PERIOD_NS;
  localparam int PRES_LOW_OD_CYC = PRES_LOW_OD_NS / CLK_PERIOD_NS;

  localparam int TMR_W = 17;
  localparam logic [TMR_W-1:0] TMR_MAX = 17'h1FFFF;

  typedef enum logic [7:0] {
    SWR_IDLE = 8'h01,
    SWR_CMD = 8'h02,
    SWR_MATCH = 8'h04,
    SWR_SEARCH = 8'h08,
    SWR_READ_ID = 8'h10,
    SWR_SELECTED = 8'h20,
    SWR_IGNORE = 8'h40,
    SWR_PRESENCE = 8'h80
  } swr_state_t;

  // search triplet phase
  typedef enum logic [2:0] {
    SWR_TRI_TRUE = 3'h1,
    SWR_TRI_COMP = 3'h2,
    SWR_TRI_DIR = 3'h4
  } swr_tri_t;

  typedef struct packed {
    logic selected;
    logic resume_flag;
    logic overdrive_flag;
  } swr_status_t;

endpackage

// File: verilog/swr_rom_layer.sv
// Behaviour
// - match rom compares 64 id bits, else silent
// - search walks id lsb first in triplets
// - drive true bit then complement bit
// - third slot mismatch drops out of search
// - skip rom selects without id
// - resume selects when resume flag set
// - resume flag set by match or search success
// - other device selected clears resume flag
// - overdrive skip sets overdrive flag, selects
// - long reset clears overdrive flag
// - overdrive match sets flag on exact match
// - overdrive flag kept during later overdrive match
// - only self falling edge is presence pulse
// - wait after reset release then presence low
// - one bit per time slot
// - falling edge starts slot timer
// - read zero held low by timer, one released
// - rom commands are eight bits after presence
// - read rom sends the 64-bit id
// - low beyond reset time is a reset
module swr_rom_layer (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic line_in,
  output logic line_out,
  output logic line_oe_out,
  input wire logic [63:0] rom_id_in,
  output logic selected_out,
  output logic slot_strobe_out,
  output logic slot_bit_out,
  output logic reset_seen_out,
  output swr_pkg::swr_status_t status_out
);

  // ---------------------------------------------------------------
  // line synchroniser and edge detect
  // ---------------------------------------------------------------
  logic sync1_reg, sync2_reg, line_prev_reg;
  logic fall, rise;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      line_prev_reg <= 1'b1;
    end else begin
      sync1_reg <= line_in;
      sync2_reg <= sync1_reg;
      line_prev_reg <= sync2_reg;
    end
  end

  assign fall = line_prev_reg & ~sync2_reg;
  assign rise = ~line_prev_reg & sync2_reg;

  // ---------------------------------------------------------------
  // state and flags
  // ---------------------------------------------------------------
  swr_pkg::swr_state_t state_reg;
  swr_pkg::swr_tri_t tri_reg;
  logic [swr_pkg::TMR_W-1:0] tmr_reg, low_reg;
  logic [7:0] cmd_reg;
  logic [6:0] idx_reg;
  logic [2:0] cmd_cnt_reg;
  logic match_ok_reg, od_match_reg, resume_reg, od_reg, pres_wait_reg;
  logic tx_bit_reg, tx_act_reg, drive_reg, sampled_reg, strobe_reg, bit_reg, rst_pulse_reg;
  logic id_bit, bus_reset, long_reset, sample_now, release_now, pres_done;

  function automatic logic [swr_pkg::TMR_W-1:0] cyc(input int n);
    cyc = n[swr_pkg::TMR_W-1:0];
  endfunction

  assign id_bit = rom_id_in[idx_reg[5:0]];
  // low-time measured while line held low; own pulldown never counts as a reset
  assign bus_reset = ~sync2_reg & ~drive_reg &
    (low_reg == cyc(od_reg ? swr_pkg::RST_OD_CYC : swr_pkg::RST_STD_CYC));
  assign long_reset = rise & (low_reg >= cyc(swr_pkg::RST_LONG_CYC));
  assign sample_now = (tmr_reg == cyc(od_reg ? swr_pkg::SAMPLE_OD_CYC
                                             : swr_pkg::SAMPLE_STD_CYC));
  assign release_now = (tmr_reg == cyc(od_reg ? swr_pkg::HOLD0_OD_CYC
                                              : swr_pkg::HOLD0_STD_CYC));
  assign pres_done = (tmr_reg >= cyc(od_reg ? swr_pkg::PRES_LOW_OD_CYC
                                            : swr_pkg::PRES_LOW_STD_CYC));

  // ---------------------------------------------------------------
  // low-time and slot timers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      low_reg <= '0;
    end else if (sync2_reg) begin
      low_reg <= '0;
    end else if (low_reg != swr_pkg::TMR_MAX) begin
      low_reg <= low_reg + cyc(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tmr_reg <= '0;
    end else if (fall || (rise && state_reg == swr_pkg::SWR_PRESENCE)) begin
      tmr_reg <= cyc(1);
    end else if (tmr_reg != swr_pkg::TMR_MAX) begin
      tmr_reg <= tmr_reg + cyc(1);
    end
  end

  // ---------------------------------------------------------------
  // slot sampling, one bit per slot
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sampled_reg <= 1'b1;
      strobe_reg <= 1'b0;
      bit_reg <= 1'b0;
    end else begin
      strobe_reg <= 1'b0;
      if (fall) begin
        sampled_reg <= 1'b0;
      end else if (sample_now && !sampled_reg && state_reg != swr_pkg::SWR_PRESENCE) begin
        sampled_reg <= 1'b1;
        strobe_reg <= 1'b1;
        bit_reg <= sync2_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // line driver: read data zero and presence pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      drive_reg <= 1'b0;
    end else if (state_reg == swr_pkg::SWR_PRESENCE) begin
      drive_reg <= ~pres_wait_reg & ~pres_done;
    end else if (fall && tx_act_reg && !tx_bit_reg) begin
      drive_reg <= 1'b1;
    end else if (release_now || bus_reset) begin
      drive_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // rom function layer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_reg <= swr_pkg::SWR_IDLE;
      tri_reg <= swr_pkg::SWR_TRI_TRUE;
      cmd_reg <= '0;
      cmd_cnt_reg <= '0;
      idx_reg <= '0;
      match_ok_reg <= 1'b0;
      od_match_reg <= 1'b0;
      pres_wait_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      tx_bit_reg <= 1'b1;
      rst_pulse_reg <= 1'b0;
    end else begin
      rst_pulse_reg <= 1'b0;
      if (bus_reset) begin
        state_reg <= swr_pkg::SWR_PRESENCE;
        pres_wait_reg <= 1'b1;
        tx_act_reg <= 1'b0;
        rst_pulse_reg <= 1'b1;
      end else begin
        unique case (state_reg)
          swr_pkg::SWR_PRESENCE: begin
            // wait counted from the rise, not from the reset pulse
            if (pres_wait_reg && sync2_reg && !rise &&
                tmr_reg >= cyc(od_reg ? swr_pkg::PRES_WAIT_OD_CYC
                                      : swr_pkg::PRES_WAIT_STD_CYC)) begin
              pres_wait_reg <= 1'b0;
            end else if (!pres_wait_reg && pres_done) begin
              state_reg <= swr_pkg::SWR_CMD;
              cmd_cnt_reg <= '0;
            end
          end
          swr_pkg::SWR_CMD: begin
            if (strobe_reg) begin
              cmd_reg <= {bit_reg, cmd_reg[7:1]};
              cmd_cnt_reg <= cmd_cnt_reg + 3'h1;
              if (cmd_cnt_reg == 3'h7) begin
                idx_reg <= '0;
                match_ok_reg <= 1'b1;
                tri_reg <= swr_pkg::SWR_TRI_TRUE;
                od_match_reg <= 1'b0;
                unique case ({bit_reg, cmd_reg[7:1]})
                  swr_pkg::CMD_MATCH_ROM: state_reg <= swr_pkg::SWR_MATCH;
                  swr_pkg::CMD_OD_MATCH: begin
                    state_reg <= swr_pkg::SWR_MATCH;
                    od_match_reg <= 1'b1;
                  end
                  swr_pkg::CMD_SEARCH_ROM: begin
                    state_reg <= swr_pkg::SWR_SEARCH;
                    tx_act_reg <= 1'b1;
                    tx_bit_reg <= rom_id_in[0];
                  end
                  swr_pkg::CMD_READ_ROM: begin
                    state_reg <= swr_pkg::SWR_READ_ID;
                    tx_act_reg <= 1'b1;
                    tx_bit_reg <= rom_id_in[0];
                  end
                  swr_pkg::CMD_SKIP_ROM,
                  swr_pkg::CMD_OD_SKIP: state_reg <= swr_pkg::SWR_SELECTED;
                  swr_pkg::CMD_RESUME: begin
                    state_reg <= resume_reg ? swr_pkg::SWR_SELECTED
                                            : swr_pkg::SWR_IGNORE;
                  end
                  default: state_reg <= swr_pkg::SWR_IGNORE;
                endcase
              end
            end
          end
          swr_pkg::SWR_MATCH: begin
            if (strobe_reg) begin
              idx_reg <= idx_reg + 7'h01;
              if (idx_reg == 7'(swr_pkg::ID_BITS - 1)) begin
                state_reg <= (match_ok_reg && bit_reg == id_bit) ? swr_pkg::SWR_SELECTED
                                                                 : swr_pkg::SWR_IGNORE;
              end else if (bit_reg != id_bit) begin
                match_ok_reg <= 1'b0;
              end
            end
          end
          swr_pkg::SWR_SEARCH: begin
            if (strobe_reg) begin
              unique case (tri_reg)
                swr_pkg::SWR_TRI_TRUE: begin
                  tri_reg <= swr_pkg::SWR_TRI_COMP;
                  tx_bit_reg <= ~id_bit;
                end
                swr_pkg::SWR_TRI_COMP: begin
                  tri_reg <= swr_pkg::SWR_TRI_DIR;
                  tx_act_reg <= 1'b0;
                end
                swr_pkg::SWR_TRI_DIR: begin
                  tri_reg <= swr_pkg::SWR_TRI_TRUE;
                  if (bit_reg != id_bit) begin
                    state_reg <= swr_pkg::SWR_IGNORE;
                    match_ok_reg <= 1'b0;
                  end else if (idx_reg == 7'(swr_pkg::ID_BITS - 1)) begin
                    state_reg <= swr_pkg::SWR_SELECTED;
                  end else begin
                    idx_reg <= idx_reg + 7'h01;
                    tx_act_reg <= 1'b1;
                    tx_bit_reg <= rom_id_in[idx_reg[5:0] + 6'h01];
                  end
                end
              endcase
            end
          end
          swr_pkg::SWR_READ_ID: begin
            if (strobe_reg) begin
              if (idx_reg == 7'(swr_pkg::ID_BITS - 1)) begin
                state_reg <= swr_pkg::SWR_SELECTED;
                tx_act_reg <= 1'b0;
              end else begin
                idx_reg <= idx_reg + 7'h01;
                tx_bit_reg <= rom_id_in[idx_reg[5:0] + 6'h01];
              end
            end
          end
          swr_pkg::SWR_SELECTED,
          swr_pkg::SWR_IGNORE,
          swr_pkg::SWR_IDLE: begin
            tx_act_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // resume and overdrive flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      resume_reg <= 1'b0;
    end else if (strobe_reg && state_reg == swr_pkg::SWR_MATCH &&
                 idx_reg == 7'(swr_pkg::ID_BITS - 1)) begin
      resume_reg <= match_ok_reg && bit_reg == id_bit;
    end else if (strobe_reg && state_reg == swr_pkg::SWR_SEARCH &&
                 tri_reg == swr_pkg::SWR_TRI_DIR) begin
      if (bit_reg != id_bit) begin
        resume_reg <= 1'b0;
      end else if (idx_reg == 7'(swr_pkg::ID_BITS - 1)) begin
        resume_reg <= 1'b1;
      end
    end else if (strobe_reg && state_reg == swr_pkg::SWR_CMD && cmd_cnt_reg == 3'h7 &&
                 ({bit_reg, cmd_reg[7:1]} == swr_pkg::CMD_SKIP_ROM ||
                  {bit_reg, cmd_reg[7:1]} == swr_pkg::CMD_OD_SKIP)) begin
      resume_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      od_reg <= 1'b0;
    end else if (long_reset) begin
      od_reg <= 1'b0;
    end else if (strobe_reg && state_reg == swr_pkg::SWR_CMD && cmd_cnt_reg == 3'h7 &&
                 {bit_reg, cmd_reg[7:1]} == swr_pkg::CMD_OD_SKIP) begin
      od_reg <= 1'b1;
    end else if (strobe_reg && state_reg == swr_pkg::SWR_MATCH && od_match_reg &&
                 idx_reg == 7'(swr_pkg::ID_BITS - 1) && match_ok_reg && bit_reg == id_bit) begin
      od_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      selected_out <= 1'b0;
      slot_strobe_out <= 1'b0;
      slot_bit_out <= 1'b0;
      reset_seen_out <= 1'b0;
      status_out <= '0;
    end else begin
      selected_out <= (state_reg == swr_pkg::SWR_SELECTED);
      slot_strobe_out <= strobe_reg & (state_reg == swr_pkg::SWR_SELECTED);
      slot_bit_out <= bit_reg;
      reset_seen_out <= rst_pulse_reg;
      status_out <= '{selected: state_reg == swr_pkg::SWR_SELECTED,
                      resume_flag: resume_reg, overdrive_flag: od_reg};
    end
  end

  assign line_out = 1'b0;
  assign line_oe_out = drive_reg;

endmodule

// File: dv/swr_checker.sv
module swr_checker (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic line_in,
  input wire logic line_out,
  input wire logic line_oe_out,
  input wire logic selected_out,
  input wire logic slot_strobe_out,
  input wire logic reset_seen_out,
  input wire swr_pkg::swr_status_t status_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // run lengths of the bus level and of the pulldown
  // ---------------------------------------------------------------
  logic [16:0] lo_cnt, last_lo, hi_cnt, oe_cnt, fall_cnt;
  logic line_d, rst_len, long_len;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      line_d <= 1'b1;
      lo_cnt <= 17'h0;
      last_lo <= 17'h0;
      hi_cnt <= 17'h0;
      oe_cnt <= 17'h0;
      fall_cnt <= 17'h0;
    end else begin
      line_d <= line_in;
      lo_cnt <= line_in ? 17'h0 : lo_cnt + 17'h1;
      hi_cnt <= line_in ? hi_cnt + 17'h1 : 17'h0;
      oe_cnt <= line_oe_out ? oe_cnt + 17'h1 : 17'h0;
      fall_cnt <= (line_d && !line_in) ? 17'h0 : fall_cnt + 17'h1;
      if (line_in && !line_d) begin
        last_lo <= lo_cnt;
      end
    end
  end
  always_comb begin
    rst_len = lo_cnt >= 17'(swr_pkg::RST_OD_CYC) || last_lo >= 17'(swr_pkg::RST_OD_CYC);
    long_len = lo_cnt >= 17'(swr_pkg::RST_LONG_CYC) || last_lo >= 17'(swr_pkg::RST_LONG_CYC);
  end
  function automatic logic near(input logic [16:0] v, input int t);
    return int'(v) >= t - 8 && int'(v) <= t + 8;
  endfunction
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  out_low_a: assert property (line_out == 1'b0)
    else $error("line data output not low");
  oe_start_a: assert property ($rose(line_oe_out) |->
    hi_cnt == 17'h0 || hi_cnt >= 17'(swr_pkg::PRES_WAIT_OD_CYC))
    else $error("pulldown started without a master edge");
  oe_len_a: assert property ($fell(line_oe_out) |->
    near(oe_cnt, swr_pkg::HOLD0_OD_CYC) || near(oe_cnt, swr_pkg::HOLD0_STD_CYC) ||
    near(oe_cnt, swr_pkg::PRES_LOW_OD_CYC) || near(oe_cnt, swr_pkg::PRES_LOW_STD_CYC))
    else $error("pulldown length wrong");
  reset_len_a: assert property (reset_seen_out |-> rst_len)
    else $error("bus reset seen on short low");
  sel_end_a: assert property ($fell(selected_out) |-> rst_len)
    else $error("selection dropped without bus reset");
  od_clear_a: assert property ($fell(status_out.overdrive_flag) |-> long_len)
    else $error("overdrive dropped without long reset");
  od_sel_a: assert property ($rose(status_out.overdrive_flag) |-> status_out.selected)
    else $error("overdrive set without selection");
  resume_sel_a: assert property ($rose(status_out.resume_flag) |-> status_out.selected)
    else $error("resume flag set without selection");
  strobe_time_a: assert property (slot_strobe_out |->
    near(fall_cnt, swr_pkg::SAMPLE_OD_CYC) || near(fall_cnt, swr_pkg::SAMPLE_STD_CYC))
    else $error("slot sampled at wrong time");
  cover property (status_out.resume_flag && selected_out);
  cover property ($rose(status_out.overdrive_flag));
  cover property (slot_strobe_out);
endmodule

bind swr_rom_layer swr_checker swr_checker_i (.clk_sys_in, .rst_n_in, .line_in, .line_out,
  .line_oe_out, .selected_out, .slot_strobe_out, .reset_seen_out, .status_out);

// File: dv/swr_master.sv
module swr_master (
  input wire logic clk_sys_in,
  input wire logic line_in,
  output logic pull_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic od = 1'b0;
  initial pull_out = 1'b0;
  // every low phase starts here, at a clock edge
  task automatic drive(input logic low, input int n);
    pull_out <= low;
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic bus_reset(input int low_n, output logic pres);
    drive(1'b1, low_n);
    drive(1'b0, od ? 875 : 8750);
    pres = !line_in;
    drive(1'b0, od ? 1075 : 10050);
  endtask
  task automatic wbit(input logic b);
    drive(1'b1, b ? 125 : (od ? 400 : 3800));
    drive(1'b0, b ? (od ? 315 : 3725) : (od ? 40 : 50));
  endtask
  task automatic rbit(output logic b);
    drive(1'b1, 125);
    drive(1'b0, od ? 125 : 1750);
    b = line_in;
    drive(1'b0, od ? 410 : 4125);
  endtask
  task automatic wbyte(input logic [7:0] c);
    for (int i = 0; i < 8; i++) wbit(c[i]);
  endtask
endmodule

// File: dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // identifier value is arbitrary
  localparam logic [63:0] ROM_ID = 64'hA5C3_1E60_9B24_7D81;
  logic clk_sys_in, rst_n_in, pull, line_out, line_oe_out, selected_out;
  logic slot_strobe_out, slot_bit_out, reset_seen_out, pres, a, b, got;
  wire logic bus_line;
  swr_pkg::swr_status_t status_out;
  int num_errors = 0;
  int n_compared = 0;
  int n_resets = 0;
  // pulled-up open-drain line
  assign bus_line = !(pull || line_oe_out === 1'b1);
  swr_rom_layer swr_rom_layer_i (.clk_sys_in, .rst_n_in, .line_in(bus_line), .line_out,
    .line_oe_out, .rom_id_in(ROM_ID), .selected_out, .slot_strobe_out, .slot_bit_out,
    .reset_seen_out, .status_out);
  swr_master swr_master_i (.clk_sys_in, .line_in(bus_line), .pull_out(pull));
  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [63:0] got_v, input logic [63:0] exp_v);
    n_compared++;
    if (got_v !== exp_v) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got_v, exp_v);
    end
  endtask
  task automatic results();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) if (slot_strobe_out === 1'b1) got <= slot_bit_out;
  always @(posedge clk_sys_in) if (reset_seen_out === 1'b1) n_resets++;
  initial begin
    repeat (190000) @(posedge clk_sys_in);
    num_errors++;
    results();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_presence();
    check({selected_out, line_oe_out, line_out, status_out}, 6'h0);
    swr_master_i.bus_reset(15100, pres);
    check({pres, status_out}, 4'h8);
    check(n_resets, 1);
  endtask
  task automatic t_od_skip();
    swr_master_i.wbyte(swr_pkg::CMD_OD_SKIP);
    check({selected_out, status_out.overdrive_flag}, 2'b11);
    swr_master_i.od = 1'b1;
  endtask
  task automatic t_match();
    swr_master_i.bus_reset(2100, pres);
    check({pres, selected_out}, 2'b10);
    swr_master_i.wbyte(swr_pkg::CMD_MATCH_ROM);
    for (int i = 0; i < 63; i++) swr_master_i.wbit(ROM_ID[i]);
    check(selected_out, 1'b0);
    swr_master_i.wbit(ROM_ID[63]);
    check(status_out, 3'h7);
  endtask
  task automatic t_resume();
    swr_master_i.bus_reset(2100, pres);
    check({pres, selected_out}, 2'b10);
    swr_master_i.wbyte(swr_pkg::CMD_RESUME);
    check(status_out, 3'h7);
    swr_master_i.wbit(1'b0);
    check(got, 1'b0);
    swr_master_i.wbit(1'b1);
    check(got, 1'b1);
  endtask
  task automatic t_search();
    swr_master_i.bus_reset(2100, pres);
    swr_master_i.wbyte(swr_pkg::CMD_SEARCH_ROM);
    for (int i = 0; i < 2; i++) begin
      swr_master_i.rbit(a);
      swr_master_i.rbit(b);
      check({a, b}, {ROM_ID[i], ~ROM_ID[i]});
      swr_master_i.wbit(ROM_ID[i] ^ (i == 1));
    end
    swr_master_i.rbit(a);
    swr_master_i.rbit(b);
    check({a, b, selected_out}, 3'b110);
  endtask
  task automatic t_misc();
    logic [3:0] r;
    swr_master_i.bus_reset(2100, pres);
    swr_master_i.wbyte(swr_pkg::CMD_SKIP_ROM);
    check(status_out, 3'h5);
    swr_master_i.bus_reset(2100, pres);
    swr_master_i.wbyte(swr_pkg::CMD_READ_ROM);
    for (int i = 0; i < 4; i++) swr_master_i.rbit(r[i]);
    check(r, ROM_ID[3:0]);
    swr_master_i.bus_reset(2100, pres);
    swr_master_i.wbyte(8'h00);
    check({selected_out, status_out}, 4'h1);
  endtask
  initial begin
    rst_n_in = 1'b0;
    repeat (16) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    t_presence();
    t_od_skip();
    t_match();
    t_resume();
    t_search();
    t_misc();
    results();
  end
endmodule
